// >>> hw/lpmc_consts.vh
// Constants of the low power mode controller
`ifndef LPMC_CONSTS_VH
`define LPMC_CONSTS_VH
// Register byte offsets
`define LPMC_OFS_MODE_SEL 8'h40
`define LPMC_OFS_CLK_GATE 8'h44
`define LPMC_OFS_OSC_CTRL 8'h48
`define LPMC_OFS_STATUS 8'h4C
// Field layout
`define LPMC_MODE_MSB 2
`define LPMC_MODE_DEEP 3'h2
`define LPMC_MODE_SLEEP 3'h4
`define LPMC_OSC_FAST_EN 0
`define LPMC_OSC_FLASH_EN 1
`define LPMC_OSC_LVD_EN 2
`define LPMC_OSC_HS_RUN 3
// Reset values
`define LPMC_MODE_RESET 3'h0
`define LPMC_GATE_RESET 32'h0100000F
`define LPMC_OSC_RESET 4'hF
// Timing
`define LPMC_CLK_MHZ 25
`define LPMC_EXT_OSC_CLKS 2048
`define LPMC_INT_OSC_CLKS 32
`define LPMC_DEEP_WAKE_US 10
`define LPMC_DEEP_WAKE_CYC (`LPMC_DEEP_WAKE_US * `LPMC_CLK_MHZ)
`define LPMC_SLEEP_WAKE_CYC (`LPMC_EXT_OSC_CLKS + `LPMC_INT_OSC_CLKS)
`endif

// >>> hw/lpmc_sync.v
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
`default_nettype none
module lpmc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Data
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage_a;
  reg [WIDTH-1:0] stage_b;
  always @(posedge clk_i) begin
    if (reset_i) begin
      stage_a <= {WIDTH{1'b0}};
      stage_b <= {WIDTH{1'b0}};
    end else begin
      stage_a <= async_i;
      stage_b <= stage_a;
    end
  end
  assign sync_o = stage_b;
endmodule
`default_nettype wire

// >>> hw/lpmc_wake_timer.v
// Down counter for the oscillator stabilisation wait
`timescale 1ns/100ps
`default_nettype none
module lpmc_wake_timer #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Control
  input wire load_i,
  input wire [WIDTH-1:0] count_i,
  output wire done_o
);
  reg [WIDTH-1:0] remain;
  always @(posedge clk_i) begin
    if (reset_i) begin
      remain <= {WIDTH{1'b0}};
    end else if (load_i) begin
      remain <= count_i;
    end else if (remain != {WIDTH{1'b0}}) begin
      remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  assign done_o = (remain == {WIDTH{1'b0}}) && !load_i;
endmodule
`default_nettype wire

// >>> hw/lpmc_ctrl.v
// Low power mode controller with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "lpmc_consts.vh"
module lpmc_ctrl #(
  parameter NUM_IRQ = 32,
  parameter NUM_GPIO = 16,
  parameter WAKE_WIDTH = 12
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // Core side
  input wire wfi_i,
  input wire [NUM_IRQ-1:0] irq_i,
  input wire timer16_unit_zero_irq_i,
  input wire timer16_unit_one_irq_i,
  // GPIO wake requests and sense type (1 = level)
  input wire [NUM_GPIO-1:0] gpio_irq_i,
  input wire [NUM_GPIO-1:0] gpio_level_sense_i,
  // Reset pin, active low, asynchronous to clk_i
  input wire reset_pin_n_i,
  // Peripheral read-back gating
  input wire [31:0] periph_rdata_i,
  input wire [4:0] periph_rd_sel_i,
  output reg [31:0] periph_rdata_o,
  // Clock and power controls
  output reg core_clk_en_o,
  output reg [31:0] periph_clk_en_o,
  output reg fast_osc_en_o,
  output reg slow_osc_en_o,
  output reg flash_en_o,
  output reg lvd_en_o,
  output reg debug_keep_o,
  output reg hold_pins_o,
  output reg chip_reset_o,
  output reg [1:0] power_state_o,
  output reg wake_pulse_o
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam ST_NORMAL = 3'h0;
  localparam ST_SLEEP = 3'h1;
  localparam ST_DEEP = 3'h2;
  localparam ST_WAKE = 3'h3;
  // Both waits must fit in WAKE_WIDTH bits; the cut below only drops zero bits
  localparam integer SLEEP_WAIT_CYC = `LPMC_SLEEP_WAKE_CYC;
  localparam integer DEEP_WAIT_CYC = `LPMC_DEEP_WAKE_CYC;
  localparam [WAKE_WIDTH-1:0] SLEEP_WAIT = SLEEP_WAIT_CYC[WAKE_WIDTH-1:0];
  localparam [WAKE_WIDTH-1:0] DEEP_WAIT = DEEP_WAIT_CYC[WAKE_WIDTH-1:0];

  function [1:0] lpmc_decode;
    input [2:0] mode;
    begin
      case (mode)
        `LPMC_MODE_DEEP: lpmc_decode = 2'h2;
        `LPMC_MODE_SLEEP: lpmc_decode = 2'h1;
        default: lpmc_decode = 2'h0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Synchronised pins
  // ------------------------------------------------------------
  wire [NUM_GPIO:0] pins_sync;
  wire [NUM_GPIO-1:0] gpio_sync;
  wire pin_reset_sync;
  lpmc_sync #(
    .WIDTH(NUM_GPIO + 1)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({~reset_pin_n_i, gpio_irq_i}),
    .sync_o(pins_sync)
  );
  assign gpio_sync = pins_sync[NUM_GPIO-1:0];
  assign pin_reset_sync = pins_sync[NUM_GPIO];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [2:0] mode_sel;
  reg [31:0] clk_gate;
  reg [3:0] osc_ctrl;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] entered;
  reg ph_valid;
  reg ph_write;
  reg [7:0] ph_addr;
  reg [31:0] rdata;
  reg timer_load;
  reg [WAKE_WIDTH-1:0] timer_count;
  wire timer_done;

  lpmc_wake_timer #(
    .WIDTH(WAKE_WIDTH)
  ) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(timer_load),
    .count_i(timer_count),
    .done_o(timer_done)
  );

  // ------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ------------------------------------------------------------
  wire addr_phase = hsel_i && htrans_i[1] && hready_i;
  always @(posedge clk_i) begin
    if (reset_i) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_valid <= addr_phase;
      ph_write <= hwrite_i;
      ph_addr <= haddr_i[7:0];
    end
  end

  // Mode field is only changed by software, never by wakeup
  always @(posedge clk_i) begin
    if (reset_i) begin
      mode_sel <= `LPMC_MODE_RESET;
      clk_gate <= `LPMC_GATE_RESET;
      osc_ctrl <= `LPMC_OSC_RESET;
    end else if (ph_valid && ph_write) begin
      case (ph_addr)
        `LPMC_OFS_MODE_SEL: mode_sel <= hwdata_i[`LPMC_MODE_MSB:0];
        `LPMC_OFS_CLK_GATE: clk_gate <= hwdata_i;
        `LPMC_OFS_OSC_CTRL: osc_ctrl <= hwdata_i[3:0];
        default: ;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      rdata <= 32'h00000000;
    end else if (addr_phase && !hwrite_i) begin
      case (haddr_i[7:0])
        `LPMC_OFS_MODE_SEL: rdata <= {29'h0, mode_sel};
        `LPMC_OFS_CLK_GATE: rdata <= clk_gate;
        `LPMC_OFS_OSC_CTRL: rdata <= {28'h0, osc_ctrl};
        `LPMC_OFS_STATUS: rdata <= {27'h0, state, power_state_o};
        default: rdata <= 32'h00000000;
      endcase
    end
  end
  assign hrdata_o = rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ------------------------------------------------------------
  // Wake sources
  // ------------------------------------------------------------
  // Level-sensitive pins are masked so a held level cannot end Deep-sleep
  wire gpio_edge_wake = |(gpio_sync & ~gpio_level_sense_i);
  wire deep_wake = gpio_edge_wake || timer16_unit_zero_irq_i
                   || timer16_unit_one_irq_i;
  wire sleep_wake = (|irq_i) || (|gpio_sync) || timer16_unit_zero_irq_i
                    || timer16_unit_one_irq_i;

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    timer_load = 1'b0;
    timer_count = {WAKE_WIDTH{1'b0}};
    case (state)
      ST_NORMAL: begin
        if (wfi_i && lpmc_decode(mode_sel) == 2'h2) begin
          next_state = ST_DEEP;
        end else if (wfi_i && lpmc_decode(mode_sel) == 2'h1) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (sleep_wake) begin
          if (osc_ctrl[`LPMC_OSC_HS_RUN]) begin
            next_state = ST_NORMAL;
          end else begin
            next_state = ST_WAKE;
            timer_load = 1'b1;
            timer_count = SLEEP_WAIT;
          end
        end
      end
      ST_DEEP: begin
        if (deep_wake) begin
          next_state = ST_WAKE;
          timer_load = 1'b1;
          timer_count = DEEP_WAIT;
        end
      end
      ST_WAKE: begin
        if (timer_done) begin
          next_state = ST_NORMAL;
        end
      end
      default: next_state = ST_NORMAL;
    endcase
  end

  always @(posedge clk_i) begin
    if (reset_i || pin_reset_sync) begin
      state <= ST_NORMAL;
      entered <= 2'h0;
    end else begin
      state <= next_state;
      if (state == ST_NORMAL && next_state == ST_DEEP) begin
        entered <= 2'h2;
      end else if (state == ST_NORMAL && next_state == ST_SLEEP) begin
        entered <= 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Clock and power outputs
  // ------------------------------------------------------------
  // Outputs follow the next state, so they move at the edge that moves the state, except a reset-pin return to Normal, which they follow one edge later
  reg next_core_clk_en;
  reg [31:0] next_periph_clk_en;
  reg next_fast_osc_en;
  reg next_slow_osc_en;
  reg next_flash_en;
  reg next_lvd_en;
  reg next_debug_keep;
  reg next_hold_pins;
  reg [1:0] next_power_state;
  reg next_wake_pulse;

  always @* begin
    next_core_clk_en = (next_state == ST_NORMAL);
    next_hold_pins = (next_state != ST_NORMAL);
    next_debug_keep = (next_state != ST_DEEP);
    next_wake_pulse = (state != ST_NORMAL) && (next_state == ST_NORMAL)
                      && !pin_reset_sync;
    // The mode shows from the entry edge on and is kept while waking
    case (next_state)
      ST_SLEEP: next_power_state = 2'h1;
      ST_DEEP: next_power_state = 2'h2;
      ST_WAKE: next_power_state = entered;
      default: next_power_state = 2'h0;
    endcase
    if (next_state == ST_DEEP) begin
      next_periph_clk_en = 32'h00000000;
      next_fast_osc_en = 1'b0;
      next_slow_osc_en = 1'b0;
      next_flash_en = osc_ctrl[`LPMC_OSC_FLASH_EN];
      next_lvd_en = osc_ctrl[`LPMC_OSC_LVD_EN];
    end else begin
      next_periph_clk_en = clk_gate;
      // Forced on outside Sleep so the wake wait has a running oscillator to settle
      next_fast_osc_en = osc_ctrl[`LPMC_OSC_FAST_EN] || (next_state != ST_SLEEP);
      next_slow_osc_en = 1'b1;
      next_flash_en = osc_ctrl[`LPMC_OSC_FLASH_EN] || (next_state == ST_NORMAL);
      next_lvd_en = osc_ctrl[`LPMC_OSC_LVD_EN];
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (reset_i) begin
      core_clk_en_o <= 1'b1;
      periph_clk_en_o <= `LPMC_GATE_RESET;
      fast_osc_en_o <= 1'b1;
      slow_osc_en_o <= 1'b1;
      flash_en_o <= 1'b1;
      lvd_en_o <= 1'b1;
      debug_keep_o <= 1'b1;
      hold_pins_o <= 1'b0;
      chip_reset_o <= 1'b1;
      power_state_o <= 2'h0;
      wake_pulse_o <= 1'b0;
    end else begin
      chip_reset_o <= pin_reset_sync;
      wake_pulse_o <= next_wake_pulse;
      core_clk_en_o <= next_core_clk_en;
      hold_pins_o <= next_hold_pins;
      debug_keep_o <= next_debug_keep;
      power_state_o <= next_power_state;
      periph_clk_en_o <= next_periph_clk_en;
      fast_osc_en_o <= next_fast_osc_en;
      slow_osc_en_o <= next_slow_osc_en;
      flash_en_o <= next_flash_en;
      lvd_en_o <= next_lvd_en;
    end
  end

  // Gated-off peripherals read as zero
  always @(posedge clk_i) begin
    if (reset_i) begin
      periph_rdata_o <= 32'h00000000;
    end else begin
      periph_rdata_o <= periph_clk_en_o[periph_rd_sel_i] ? periph_rdata_i
                        : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// >>> tb/lpmc_ctrl_assertions.sv
// Checker of the mode controller outputs
`timescale 1ns/100ps
`default_nettype none
module lpmc_ctrl_assertions (
  // Clock, reset and inputs
  input wire clk_i,
  input wire reset_i,
  input wire reset_pin_n_i,
  input wire [4:0] periph_rd_sel_i,
  // Outputs
  input wire [31:0] periph_rdata_o,
  input wire core_clk_en_o,
  input wire [31:0] periph_clk_en_o,
  input wire fast_osc_en_o,
  input wire slow_osc_en_o,
  input wire hold_pins_o,
  input wire chip_reset_o,
  input wire [1:0] power_state_o,
  input wire wake_pulse_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Cycles the core clock has been held off
  logic [15:0] low_cnt;
  always @(posedge clk_i) begin
    if (reset_i || core_clk_en_o) low_cnt <= 16'h0;
    else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h1;
  end
  a_normal_core_clk: assert property (power_state_o == 2'h0 |-> core_clk_en_o)
    else $error("core clock off in normal mode");
  a_sleep_core_off: assert property (power_state_o == 2'h1 |-> !core_clk_en_o)
    else $error("core clock running in sleep");
  a_deep_osc_off: assert property (power_state_o == 2'h2 && $past(power_state_o) == 2'h0
    |-> !fast_osc_en_o && !slow_osc_en_o && periph_clk_en_o == 32'h0)
    else $error("clocks running on deep entry");
  a_entry_pins_hold: assert property (power_state_o != 2'h0 && $past(power_state_o) == 2'h0
    |-> hold_pins_o) else $error("pins not held on entry");
  a_gated_read_zero: assert property (!periph_clk_en_o[periph_rd_sel_i]
    |=> periph_rdata_o == 32'h0) else $error("gated peripheral read not zero");
  a_wake_to_normal: assert property (wake_pulse_o |-> power_state_o == 2'h0 && core_clk_en_o
    ##1 !wake_pulse_o) else $error("wake did not return to normal");
  a_deep_wake_wait: assert property (wake_pulse_o && $past(power_state_o) == 2'h2
    |-> low_cnt >= 16'h00FA) else $error("deep wake too early");
  a_pin_reset_kept: assert property ((!reset_pin_n_i) [*4] |-> chip_reset_o)
    else $error("reset pin ignored");
endmodule
bind lpmc_ctrl lpmc_ctrl_assertions chk_u (.clk_i(clk_i), .reset_i(reset_i),
  .reset_pin_n_i(reset_pin_n_i), .periph_rd_sel_i(periph_rd_sel_i),
  .periph_rdata_o(periph_rdata_o), .core_clk_en_o(core_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .fast_osc_en_o(fast_osc_en_o),
  .slow_osc_en_o(slow_osc_en_o), .hold_pins_o(hold_pins_o), .chip_reset_o(chip_reset_o),
  .power_state_o(power_state_o), .wake_pulse_o(wake_pulse_o));
`default_nettype wire

// >>> tb/lpmc_core_model.sv
// Core and interrupt source model facing the controller
`timescale 1ns/100ps
`default_nettype none
module lpmc_core_model (
  // Clock, reset and bench commands
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wfi_cmd_i,
  input wire logic fire_i,
  input wire logic clr_i,
  input wire logic [1:0] src_i,
  // Controller side
  input wire logic core_clk_en_i,
  output var logic wfi_o,
  output logic [31:0] irq_o,
  output logic t0_o,
  output logic t1_o,
  output logic [15:0] gpio_o
);
  logic pend;
  logic [1:0] src_q;
  // Software writes the mode before the WFI; edge sense is set by the bench
  always @(posedge clk_i) begin
    wfi_o <= wfi_cmd_i && !reset_i;
    if (fire_i) begin
      pend <= 1'b1;
      src_q <= src_i;
    end else if (reset_i || clr_i || core_clk_en_i) begin
      pend <= 1'b0;
    end
  end
  // Source stays up until the running core services it
  assign irq_o = {28'h0, pend && src_q == 2'd0, 3'h0};
  assign t0_o = pend && src_q == 2'd1;
  assign t1_o = pend && src_q == 2'd2;
  assign gpio_o = {14'h0, pend && src_q == 2'd3, 1'b0};
endmodule
`default_nettype wire

// >>> tb/lpmc_ctrl_test.sv
// Register and mode sequence bench of the controller
`timescale 1ns/100ps
`default_nettype none
module lpmc_ctrl_test;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] htrans = 2'h0, src = 2'h0, pstate;
  logic hwrite = 1'b0, rpin_n = 1'b1, mwfi = 1'b0, mfire = 1'b0, mclr = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, hrdata, prd, pclk, irq;
  logic [15:0] sense = 16'h0, gpio;
  logic [4:0] psel = 5'd0;
  logic rdy, resp, core, fosc, sosc, flash, low_voltage_detector, dbg, hold, crst, wake, wfi, t0, t1;
  int bad_count = 0, num_checks = 0, cyc = 0, n, i;
  localparam int P_WFI = 0, P_FIRE = 1, P_CLR = 2;
  initial forever #20 clk_i = ~clk_i;
  lpmc_ctrl dut_u (.clk_i(clk_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
    .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp), .wfi_i(wfi), .irq_i(irq),
    .timer16_unit_zero_irq_i(t0), .timer16_unit_one_irq_i(t1), .gpio_irq_i(gpio),
    .gpio_level_sense_i(sense), .reset_pin_n_i(rpin_n), .periph_rdata_i(32'hA5A5A5A5),
    .periph_rd_sel_i(psel), .periph_rdata_o(prd), .core_clk_en_o(core),
    .periph_clk_en_o(pclk), .fast_osc_en_o(fosc), .slow_osc_en_o(sosc), .flash_en_o(flash),
    .lvd_en_o(low_voltage_detector), .debug_keep_o(dbg), .hold_pins_o(hold), .chip_reset_o(crst),
    .power_state_o(pstate), .wake_pulse_o(wake));
  lpmc_core_model core_u (.clk_i(clk_i), .reset_i(reset_i), .wfi_cmd_i(mwfi),
    .fire_i(mfire), .clr_i(mclr), .src_i(src), .core_clk_en_i(core), .wfi_o(wfi),
    .irq_o(irq), .t0_o(t0), .t1_o(t1), .gpio_o(gpio));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Single word transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk_i); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (rdy !== 1'b1);
    q = hrdata;
  endtask
  // Raises one model command for a single cycle, then lets four edges pass
  task automatic pulse(input int sel);
    case (sel)
      P_WFI: mwfi <= 1'b1;
      P_FIRE: mfire <= 1'b1;
      default: mclr <= 1'b1;
    endcase
    @(posedge clk_i);
    mwfi <= 1'b0;
    mfire <= 1'b0;
    mclr <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic wait_wake;
    n = 0;
    while (wake !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(0, 32'h40, 0);
    check(q, 32'h0);
    check({31'h0, resp}, 32'h0);
    bus(0, 32'h44, 0);
    check(q, 32'h0100000F);
    bus(0, 32'h48, 0);
    check(q, 32'hF);
    bus(1, 32'h80, 32'hFFFFFFFF);
    bus(0, 32'h80, 0);
    check(q, 32'h0);
    psel <= 5'd4;
    repeat (3) @(posedge clk_i);
    check(prd, 32'h0);
    bus(1, 32'h44, 32'h0100001F);
    repeat (3) @(posedge clk_i);
    check(prd, 32'hA5A5A5A5);
    check(pclk, 32'h0100001F);
    $display("registers done");
    for (i = 0; i < 8; i++) if (i != 2 && i != 4) begin
      bus(1, 32'h40, 32'(i));
      bus(0, 32'h40, 0);
      check(q, 32'(i));
      pulse(P_WFI);
      check({30'h0, pstate}, 32'h0);
    end
    $display("mode codes done");
    bus(1, 32'h48, 32'h6);
    bus(1, 32'h40, 32'h4);
    pulse(P_WFI);
    check({26'h0, pstate, core, hold, fosc, flash}, 32'h15);
    check({29'h0, low_voltage_detector, sosc, dbg}, 32'h7);
    check(pclk, 32'h0100001F);
    src <= 2'd0;
    pulse(P_FIRE);
    wait_wake();
    check(32'(n >= 2074 && n <= 2084), 32'h1);
    bus(1, 32'h48, 32'hF);
    bus(0, 32'h40, 0);
    check(q, 32'h4);
    pulse(P_WFI);
    src <= 2'd1;
    pulse(P_FIRE);
    check({30'h0, pstate}, 32'h0);
    $display("sleep done");
    bus(1, 32'h40, 32'h2);
    sense <= 16'h0002;
    pulse(P_WFI);
    check({30'h0, pstate}, 32'h2);
    check({29'h0, dbg, sosc, low_voltage_detector}, 32'h1);
    check(pclk, 32'h0);
    src <= 2'd0;
    pulse(P_FIRE);
    repeat (300) @(posedge clk_i);
    check({30'h0, pstate}, 32'h2);
    pulse(P_CLR);
    src <= 2'd3;
    pulse(P_FIRE);
    repeat (300) @(posedge clk_i);
    check({30'h0, pstate}, 32'h2);
    pulse(P_CLR);
    sense <= 16'h0;
    pulse(P_FIRE);
    wait_wake();
    check(32'(n >= 242 && n <= 252), 32'h1);
    pulse(P_WFI);
    src <= 2'd2;
    pulse(P_FIRE);
    wait_wake();
    check(32'(n >= 242 && n <= 252), 32'h1);
    $display("deep sleep done");
    pulse(P_WFI);
    rpin_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({29'h0, crst, pstate}, 32'h4);
    rpin_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    check({31'h0, crst}, 32'h0);
    $display("reset pin done");
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    bus(0, 32'h44, 0);
    check(q, 32'h0100000F);
    check({30'h0, pstate, core, hold}, 32'h2);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
